// ### common/plmx_pkg.sv
/*
  shared constants for the serial load and status select logic.
  assumes a single 50 MHz system clock; all pin inputs are asynchronous.
*/
package plmx_pkg;
  localparam int SHIFT_W = 22;
  localparam int REF_W = 14;
  localparam int MAIN_W = 11;
  localparam int CNT_W = 14;
  // control pair values, upper bit first
  localparam logic [1:0] SEL_FIRST_REF = 2'h0;
  localparam logic [1:0] SEL_FIRST_MAIN = 2'h1;
  localparam logic [1:0] SEL_SECOND_REF = 2'h2;
  localparam logic [1:0] SEL_SECOND_MAIN = 2'h3;
  // field positions in a reference latch
  localparam int POS_SEL_LO = 0;
  localparam int POS_SEL_HI = 1;
  localparam int POS_REF_LO = 2;
  localparam int POS_REF_HI = 15;
  localparam int POS_UNUSED = 16;
  localparam int POS_POLARITY = 17;
  localparam int POS_GAIN = 18;
  localparam int POS_TRISTATE = 19;
  localparam int POS_MODE_LO = 20;
  localparam int POS_MODE_HI = 21;
  // field positions in a main latch
  localparam int POS_A_LO = 2;
  localparam int POS_A_HI = 7;
  localparam int POS_B_LO = 8;
  localparam int POS_B_HI = 18;
  localparam int POS_MAIN_GAIN = 19;
  localparam logic [SHIFT_W-1:0] LATCH_RESET = 22'h000000;
  // status modes: second upper, second lower, first upper, first lower
  localparam logic [3:0] MODE_LOW = 4'h0;
  localparam logic [3:0] MODE_FIRST_LOCK = 4'h1;
  localparam logic [3:0] MODE_FIRST_REF = 4'h2;
  localparam logic [3:0] MODE_FIRST_MAIN = 4'h3;
  localparam logic [3:0] MODE_SECOND_LOCK = 4'h4;
  localparam logic [3:0] MODE_BOTH_LOCK = 4'h5;
  localparam logic [3:0] MODE_SECOND_REF = 4'h8;
  localparam logic [3:0] MODE_SECOND_MAIN = 4'h9;
  localparam logic [3:0] MODE_FAST_LOCK = 4'hA;
  localparam logic [3:0] MODE_RESET_FIRST = 4'hB;
  localparam logic [3:0] MODE_RESET_SECOND = 4'hE;
  localparam logic [3:0] MODE_RESET_BOTH = 4'hF;
  // lock detect
  localparam int LOCK_PULSES = 5;
  localparam int NARROW_NS = 15;
  localparam int CLK_NS = 20;
  localparam int NARROW_CYC = (NARROW_NS / CLK_NS) < 1 ? 1 : (NARROW_NS / CLK_NS);
  localparam int SYNC_STAGES = 2;
  // pin levels after reset, detector outputs idle high; zeros would fake a low pulse
  localparam logic [7:0] PIN_RESET = 8'hC0;
endpackage

// ### core/plmx_divider.sv
/*
  programmable divider: one output pulse per ratio input ticks.
  assumes tick is a one-cycle pulse in the clk domain.
*/
module plmx_divider
  import plmx_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic tick,
  input wire logic [W-1:0] ratio,
  output logic pulse_q
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire last = (cnt_q + W'(1) >= ratio);
  // ratio zero acts as one rather than locking up
  assign cnt_d = clr ? '0 : (tick ? (last ? '0 : cnt_q + W'(1)) : cnt_q);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pulse_q <= tick & last & ~clr;
    end
  end
endmodule

// ### core/plmx_lock_detect.sv
/*
  digital lock detect on the low-going phase detector pulses.
  assumes pfd_n is already synchronised to clk.
*/
module plmx_lock_detect
  import plmx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic pfd_n,
  output logic locked_q
);
  logic [3:0] width_q;
  logic [2:0] run_q;
  logic prev_q;
  wire rise = pfd_n & ~prev_q;
  wire narrow = (width_q <= 4'(NARROW_CYC));
  wire [3:0] width_d = pfd_n ? 4'h0 : (width_q == 4'hF ? width_q : width_q + 4'h1);
  wire [2:0] run_d = clr ? 3'h0
    : (rise ? (narrow ? (run_q == 3'(LOCK_PULSES) ? run_q : run_q + 3'h1) : 3'h0) : run_q);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      width_q <= 4'h0;
      run_q <= 3'h0;
      prev_q <= 1'b1;
      locked_q <= 1'b0;
    end else begin
      prev_q <= pfd_n;
      width_q <= width_d;
      run_q <= run_d;
      locked_q <= (run_d == 3'(LOCK_PULSES));
    end
  end
endmodule

// ### core/plmx_top.sv
/*
  serial load, four latches and status output selection of a dual loop synthesizer.
  assumes all pins are asynchronous to clk and the serial clock runs well below clk/4.
*/
module plmx_top
  import plmx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic ref_in,
  input wire logic first_loop_prescaler_in,
  input wire logic second_loop_prescaler_in,
  input wire logic first_loop_pfd_n,
  input wire logic second_loop_pfd_n,
  output logic status_select_output,
  output logic first_loop_pump_out_en,
  output logic first_loop_pump_high_current,
  output logic first_loop_detector_polarity,
  output logic second_loop_pump_out_en,
  output logic second_loop_pump_high_current,
  output logic second_loop_detector_polarity,
  output logic [REF_W-1:0] first_loop_ref_ratio,
  output logic [REF_W-1:0] second_loop_ref_ratio,
  output logic [MAIN_W-1:0] first_loop_main_b,
  output logic [MAIN_W-1:0] second_loop_main_b,
  output logic [5:0] first_loop_main_a,
  output logic [5:0] second_loop_main_a,
  output logic first_loop_locked,
  output logic second_loop_locked
);
  localparam int NPIN = 8;

  // pin synchronisers
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] sync_q;
  logic [NPIN-1:0] last_q;
  logic [NPIN-1:0] rise;

  assign pin_raw = {second_loop_pfd_n, first_loop_pfd_n,
                    second_loop_prescaler_in, first_loop_prescaler_in,
                    ref_in, load_strobe, serial_data, serial_clk};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rstn) begin
          meta_q[gi] <= PIN_RESET[gi];
          sync_q[gi] <= PIN_RESET[gi];
          last_q[gi] <= PIN_RESET[gi];
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
          last_q[gi] <= sync_q[gi];
        end
      end
      assign rise[gi] = sync_q[gi] & ~last_q[gi];
    end
  endgenerate

  wire sclk_rise = rise[0];
  wire sdata = sync_q[1];
  wire load_rise = rise[2];
  wire ref_tick = rise[3];
  wire [1:0] pre_tick = rise[5:4];
  wire [1:0] pfd_n = sync_q[7:6];

  // input shift register
  logic [SHIFT_W-1:0] shift_q;
  logic [SHIFT_W-1:0] shift_d;

  // msb enters first and ends at the top, control pair ends at bits 1..0
  assign shift_d = sclk_rise ? {shift_q[SHIFT_W-2:0], sdata} : shift_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_q <= LATCH_RESET;
    end else begin
      shift_q <= shift_d;
    end
  end

  // latch select
  logic [SHIFT_W-1:0] first_ref_q;
  logic [SHIFT_W-1:0] first_main_q;
  logic [SHIFT_W-1:0] second_ref_q;
  logic [SHIFT_W-1:0] second_main_q;

  wire [1:0] sel = {shift_q[POS_SEL_HI], shift_q[POS_SEL_LO]};
  // only the word stored at the strobe edge is taken; clock and strobe
  // edges in one sample window would race, hence the set-up time needed
  wire ld_first_ref = load_rise & (sel == SEL_FIRST_REF);
  wire ld_first_main = load_rise & (sel == SEL_FIRST_MAIN);
  wire ld_second_ref = load_rise & (sel == SEL_SECOND_REF);
  wire ld_second_main = load_rise & (sel == SEL_SECOND_MAIN);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      first_ref_q <= LATCH_RESET;
    end else if (ld_first_ref) begin
      first_ref_q <= shift_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      first_main_q <= LATCH_RESET;
    end else if (ld_first_main) begin
      first_main_q <= shift_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      second_ref_q <= LATCH_RESET;
    end else if (ld_second_ref) begin
      second_ref_q <= shift_q;
    end
  end

  // frequency and fast lock gain arrive in this single write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      second_main_q <= LATCH_RESET;
    end else if (ld_second_main) begin
      second_main_q <= shift_q;
    end
  end

  // field decode; bit 16 of a reference latch is never read
  wire first_polarity = first_ref_q[POS_POLARITY];
  wire first_gain = first_ref_q[POS_GAIN];
  wire first_tristate = first_ref_q[POS_TRISTATE];
  wire first_mode_lower = first_ref_q[POS_MODE_LO];
  wire first_mode_upper = first_ref_q[POS_MODE_HI];
  wire second_polarity = second_ref_q[POS_POLARITY];
  wire second_gain_ref = second_ref_q[POS_GAIN];
  wire second_tristate = second_ref_q[POS_TRISTATE];
  wire second_mode_lower = second_ref_q[POS_MODE_LO];
  wire second_mode_upper = second_ref_q[POS_MODE_HI];
  // fast lock gain lives in the main latch
  wire second_loop_pump_gain = second_main_q[POS_MAIN_GAIN];

  assign first_loop_ref_ratio = first_ref_q[POS_REF_HI:POS_REF_LO];
  assign second_loop_ref_ratio = second_ref_q[POS_REF_HI:POS_REF_LO];
  assign first_loop_main_b = first_main_q[POS_B_HI:POS_B_LO];
  assign second_loop_main_b = second_main_q[POS_B_HI:POS_B_LO];
  assign first_loop_main_a = first_main_q[POS_A_HI:POS_A_LO];
  assign second_loop_main_a = second_main_q[POS_A_HI:POS_A_LO];

  // status mode
  wire [3:0] mode = {second_mode_upper, second_mode_lower,
                     first_mode_upper, first_mode_lower};

  wire reset_first = (mode == MODE_RESET_FIRST) | (mode == MODE_RESET_BOTH);
  wire reset_second = (mode == MODE_RESET_SECOND) | (mode == MODE_RESET_BOTH);
  wire fast_lock = (mode == MODE_FAST_LOCK);

  // per-loop dividers and lock detect
  logic [1:0] ref_pulse;
  logic [1:0] main_pulse;
  logic [1:0] locked;
  wire [1:0] loop_clr = {reset_second, reset_first};
  wire [REF_W-1:0] ref_ratio [2];
  wire [MAIN_W-1:0] main_ratio [2];

  assign ref_ratio[0] = first_loop_ref_ratio;
  assign ref_ratio[1] = second_loop_ref_ratio;
  assign main_ratio[0] = first_loop_main_b;
  assign main_ratio[1] = second_loop_main_b;

  // both counters share one clear, so they restart on the same edge;
  // main count here is b only, prescaler swallowing is outside this block
  generate
    for (gi = 0; gi < 2; gi++) begin : g_loop
      plmx_divider #(
        .W(REF_W)
      ) u_ref (
        .clk(clk),
        .rstn(rstn),
        .clr(loop_clr[gi]),
        .tick(ref_tick),
        .ratio(ref_ratio[gi]),
        .pulse_q(ref_pulse[gi])
      );
      plmx_divider #(
        .W(MAIN_W)
      ) u_main (
        .clk(clk),
        .rstn(rstn),
        .clr(loop_clr[gi]),
        .tick(pre_tick[gi]),
        .ratio(main_ratio[gi]),
        .pulse_q(main_pulse[gi])
      );
      plmx_lock_detect u_lock (
        .clk(clk),
        .rstn(rstn),
        .clr(loop_clr[gi]),
        .pfd_n(pfd_n[gi]),
        .locked_q(locked[gi])
      );
    end
  endgenerate

  assign first_loop_locked = locked[0];
  assign second_loop_locked = locked[1];

  // analog lock passes the detector's narrow low pulses while locked
  wire first_analog = locked[0] & pfd_n[0];
  wire second_analog = locked[1] & pfd_n[1];
  wire both_analog = first_analog & second_analog;

  // status select; low mode and counter reset modes pick nothing
  wire pick_first_lock = (mode == MODE_FIRST_LOCK);
  wire pick_first_ref = (mode ==? 4'b0?10);
  wire pick_first_main = (mode ==? 4'b0?11);
  wire pick_second_lock = (mode == MODE_SECOND_LOCK);
  wire pick_both_lock = (mode == MODE_BOTH_LOCK);
  wire pick_second_ref = (mode ==? 4'b1?00);
  wire pick_second_main = (mode ==? 4'b1?01);
  wire status_d = (pick_first_lock & first_analog)
    | (pick_first_ref & ref_pulse[0])
    | (pick_first_main & main_pulse[0])
    | (pick_second_lock & second_analog)
    | (pick_both_lock & both_analog)
    | (pick_second_ref & ref_pulse[1])
    | (pick_second_main & main_pulse[1])
    | (fast_lock & second_loop_pump_gain);

  // pump controls
  logic first_en_q;
  logic second_en_q;
  logic status_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      first_en_q <= 1'b0;
      second_en_q <= 1'b0;
      status_q <= 1'b0;
    end else begin
      first_en_q <= ~first_tristate & ~reset_first;
      second_en_q <= ~second_tristate & ~reset_second;
      status_q <= status_d;
    end
  end

  assign status_select_output = status_q;
  assign first_loop_pump_out_en = first_en_q;
  assign second_loop_pump_out_en = second_en_q;
  assign first_loop_pump_high_current = first_gain;
  // fast lock also raises second-loop current while the switch is on
  assign second_loop_pump_high_current = second_gain_ref | (fast_lock & second_loop_pump_gain);
  assign first_loop_detector_polarity = first_polarity;
  assign second_loop_detector_polarity = second_polarity;
endmodule

// ### sim/plmx_host.sv
/*
  host model: shifts a word msb first, then pulses the load strobe.
  assumes clk is the bench clock; serial clock period is 8 clk.
*/
module plmx_host
  import plmx_pkg::*;
(
  input wire logic clk,
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end
  task automatic send(input logic [SHIFT_W-1:0] w);
    for (int i = SHIFT_W - 1; i >= 0; i--) begin
      @(negedge clk);
      serial_data = w[i];
      repeat (3) @(negedge clk);
      serial_clk = 1'b1;
      repeat (4) @(negedge clk);
      serial_clk = 1'b0;
    end
    serial_data = ~w[0]; // released line must not keep the last bit
    repeat (3) @(negedge clk);
    load_strobe = 1'b1;
    repeat (4) @(negedge clk);
    load_strobe = 1'b0;
  endtask
endmodule

// ### sim/plmx_top_properties.sv
/*
  port checks for the serial load and status select logic.
  assumes one clk domain and a synchronous active low rstn.
*/
module plmx_top_properties
  import plmx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic load_strobe,
  input wire logic ref_in,
  input wire logic first_loop_prescaler_in,
  input wire logic second_loop_prescaler_in,
  input wire logic first_loop_pfd_n,
  input wire logic second_loop_pfd_n,
  input wire logic status_select_output,
  input wire logic first_loop_pump_out_en,
  input wire logic second_loop_pump_out_en,
  input wire logic first_loop_pump_high_current,
  input wire logic [REF_W-1:0] first_loop_ref_ratio,
  input wire logic [REF_W-1:0] second_loop_ref_ratio,
  input wire logic first_loop_locked,
  input wire logic second_loop_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // pins pass a synchroniser, so outputs settle only some cycles after a pin edge
  logic [5:0] pin_q;
  logic [3:0] quiet_q, load_q, high_q;
  wire [5:0] pin_now = {load_strobe, ref_in, first_loop_prescaler_in,
    second_loop_prescaler_in, first_loop_pfd_n, second_loop_pfd_n};
  always_ff @(posedge clk) begin
    pin_q <= pin_now;
    quiet_q <= (!rstn || pin_now != pin_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
    load_q <= (!rstn || load_strobe != pin_q[5]) ? 4'h0 : load_q + {3'h0, load_q != 4'hF};
    high_q <= (!rstn || !first_loop_pfd_n) ? 4'h0 : high_q + {3'h0, high_q != 4'hF};
  end
  AST_RESET_CLEAR: assert property ($rose(rstn) |-> !status_select_output
    && !first_loop_locked && first_loop_ref_ratio == '0 && !first_loop_pump_out_en)
    else $error("outputs not clear after reset");
  AST_LATCH_HOLD: assert property (load_q > 4'h5 |->
    $stable({first_loop_ref_ratio, second_loop_ref_ratio})) else $error("latch moved");
  AST_PUMP_HOLD: assert property (load_q > 4'h7 |-> $stable({first_loop_pump_out_en,
    second_loop_pump_out_en, first_loop_pump_high_current})) else $error("pump moved");
  AST_STATUS_QUIET: assert property (quiet_q > 4'h8 |->
    $stable(status_select_output)) else $error("status moved while quiet");
  AST_LOCK_QUIET: assert property (quiet_q > 4'h8 |->
    $stable({first_loop_locked, second_loop_locked})) else $error("lock moved while quiet");
  AST_WIDE_FIRST: assert property (!first_loop_pfd_n [*3] ##1 first_loop_pfd_n
    |-> ##[1:6] !first_loop_locked) else $error("wide pulse kept first lock");
  AST_WIDE_SECOND: assert property (!second_loop_pfd_n [*3] ##1 second_loop_pfd_n
    |-> ##[1:6] !second_loop_locked) else $error("wide pulse kept second lock");
  AST_LOCK_RISE: assert property ($rose(first_loop_locked) |->
    high_q > 4'h0 && high_q < 4'h8) else $error("lock rose without a pulse");
endmodule

bind plmx_top plmx_top_properties u_plmx_top_properties (.*);

// ### sim/plmx_top_tb.sv
/*
  self-checking bench for the serial load and status select logic.
  assumes the host model drives the link and the checker is bound in.
*/
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module plmx_top_tb;
  import plmx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] pin_q = 5'h03; // detector outputs idle high
  int n_mismatch = 0;
  int total_checks = 0;
  int hits = 0;
  int cyc = 0;
  logic serial_clk, serial_data, load_strobe, status_select_output;
  logic first_loop_pump_out_en, first_loop_pump_high_current, first_loop_detector_polarity;
  logic second_loop_pump_out_en, second_loop_pump_high_current, second_loop_detector_polarity;
  logic first_loop_locked, second_loop_locked;
  logic [REF_W-1:0] first_loop_ref_ratio, second_loop_ref_ratio;
  logic [MAIN_W-1:0] first_loop_main_b, second_loop_main_b;
  logic [5:0] first_loop_main_a, second_loop_main_a;
  plmx_host u_plmx_host (.*);
  plmx_top u_plmx_top (.*, .ref_in(pin_q[4]), .first_loop_prescaler_in(pin_q[3]),
    .second_loop_prescaler_in(pin_q[2]), .first_loop_pfd_n(pin_q[1]),
    .second_loop_pfd_n(pin_q[0]));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (status_select_output === 1'b1) hits++;
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end
  function automatic logic [21:0] refw(logic [1:0] m, logic t, logic g, logic [13:0] r,
    logic [1:0] s);
    return {m, t, g, ~t, 1'b1, r, s};
  endfunction
  task automatic wr(logic [21:0] w);
    u_plmx_host.send(w);
    repeat (8) @(negedge clk);
  endtask
  task automatic set_mode(logic [3:0] m);
    wr(refw(m[1:0], 1'b0, 1'b1, 14'h0003, SEL_FIRST_REF));
    wr(refw(m[3:2], 1'b0, 1'b0, 14'h0002, SEL_SECOND_REF));
  endtask
  task automatic pulse(int k, int n, int w);
    repeat (n) begin
      pin_q[k] = ~pin_q[k];
      repeat (w) @(negedge clk);
      pin_q[k] = ~pin_q[k];
      repeat (3) @(negedge clk);
    end
    repeat (8) @(negedge clk);
  endtask
  task automatic t_latch();
    `CHK({first_loop_ref_ratio, status_select_output, first_loop_pump_out_en}, 16'h0)
    wr(refw(2'h0, 1'b0, 1'b1, 14'h3FFF, SEL_FIRST_REF));
    `CHK({first_loop_ref_ratio, first_loop_pump_high_current, first_loop_detector_polarity,
      first_loop_pump_out_en, second_loop_ref_ratio}, {14'h3FFF, 3'h7, 14'h0})
    wr({2'h0, 1'b0, 11'h005, 6'h2A, SEL_FIRST_MAIN});
    `CHK({first_loop_main_b, first_loop_main_a}, {11'h005, 6'h2A})
    wr(refw(2'h0, 1'b1, 1'b0, 14'h0001, SEL_SECOND_REF));
    `CHK({second_loop_ref_ratio, second_loop_pump_out_en, second_loop_detector_polarity,
      second_loop_pump_high_current}, {14'h0001, 3'h0})
    wr({2'h0, 1'b0, 11'h004, 6'h3F, SEL_SECOND_MAIN});
    `CHK({second_loop_main_b, second_loop_main_a, first_loop_ref_ratio},
      {11'h004, 6'h3F, 14'h3FFF})
    wr(refw(2'h0, 1'b1, 1'b0, 14'h0002, SEL_FIRST_REF));
    `CHK({first_loop_pump_out_en, first_loop_pump_high_current, first_loop_detector_polarity,
      first_loop_ref_ratio}, {3'h0, 14'h0002})
  endtask
  task automatic t_div();
    logic [3:0] m [8] = '{4'h0, 4'h2, 4'h6, 4'h8, 4'h3, 4'h9, 4'hC, 4'h7};
    int k [8] = '{4, 4, 4, 4, 3, 2, 4, 3};
    int n [8] = '{9, 9, 9, 8, 10, 8, 8, 10};
    int e [8] = '{0, 3, 3, 4, 2, 2, 4, 2};
    int b;
    for (int i = 0; i < 8; i++) begin
      set_mode(4'hF); // dividers start from clear
      set_mode(m[i]);
      b = hits;
      pulse(k[i], n[i], 2);
      `CHK(hits - b, e[i])
    end
  endtask
  task automatic t_fast();
    set_mode(4'hA);
    wr({2'h0, 1'b1, 11'h004, 6'h3F, SEL_SECOND_MAIN});
    `CHK({status_select_output, second_loop_pump_high_current}, 2'h3)
    wr({2'h0, 1'b0, 11'h004, 6'h3F, SEL_SECOND_MAIN});
    `CHK({status_select_output, second_loop_pump_high_current}, 2'h0)
  endtask
  task automatic t_lock();
    set_mode(4'h1);
    pulse(1, 4, 1);
    `CHK(first_loop_locked, 1'b0)
    pulse(1, 1, 1);
    `CHK({first_loop_locked, status_select_output}, 2'h3)
    set_mode(4'h5);
    `CHK(status_select_output, 1'b0)
    pulse(0, 5, 1);
    `CHK(status_select_output, 1'b1)
    set_mode(4'h4);
    `CHK(status_select_output, 1'b1)
    pulse(0, 1, 4);
    `CHK({second_loop_locked, status_select_output}, 2'h0)
    pulse(1, 1, 4);
    `CHK(first_loop_locked, 1'b0)
  endtask
  task automatic t_creset();
    logic [3:0] m [3] = '{4'hB, 4'hE, 4'hF};
    logic [1:0] en [3] = '{2'h1, 2'h2, 2'h0};
    for (int i = 0; i < 3; i++) begin
      set_mode(m[i]);
      `CHK({first_loop_pump_out_en, second_loop_pump_out_en, status_select_output},
        {en[i], 1'b0})
    end
  endtask
  task automatic t_reset();
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    `CHK({first_loop_ref_ratio, second_loop_main_b, first_loop_pump_out_en, first_loop_locked,
      second_loop_locked}, 28'h0)
    wr(refw(2'h0, 1'b0, 1'b0, 14'h0009, SEL_FIRST_REF));
    `CHK(first_loop_ref_ratio, 14'h0009)
  endtask
  task automatic results();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_latch();
    t_div();
    t_fast();
    t_lock();
    t_creset();
    t_reset();
    results();
  end
endmodule
